/* rtl/csag_core.sv */
// Status word, interrupt acceptance and effective address generation
`timescale 1ns/10ps
`default_nettype none
module csag_core
  import csag_pkg::*;
#(
  parameter int PC_W = 19
) (
  input wire logic clk,
  input wire logic srst,
  input wire csag_areq_t areq,
  input wire logic [15:0] sp,
  input wire logic [PC_W-1:0] pc,
  input wire logic [1:0] data_bank,
  input wire logic alu_valid,
  input wire logic alu_is_arith,
  input wire logic alu_word,
  input wire logic [15:0] alu_result,
  input wire logic alu_carry,
  input wire logic alu_ovf,
  input wire logic psw_wr,
  input wire logic [7:0] psw_wdata,
  input wire logic irq_req,
  input wire logic irq_nmi,
  input wire logic [1:0] irq_level,
  input wire logic irq_ie,
  input wire logic reti,
  input wire logic [7:0] stack_rdata,
  output logic [7:0] psw_q,
  output logic irq_accept,
  output logic push_valid,
  output logic [7:0] push_data,
  output logic addr_valid,
  output logic [17:0] addr_q,
  output logic addr_sfr,
  output logic addr_err,
  output logic [17:0] branch_target,
  output logic [PC_W-1:0] pc_q
);
  // ----------------------------------------------------------------
  // Status word register
  // ----------------------------------------------------------------
  csag_psw_t psw_reg, psw_next;
  logic [1:0] mask_now;
  logic admit_level, admit_mask, accept_w;
  assign mask_now = {psw_reg.mask_level_hi, psw_reg.mask_level_lo};
  // Smaller value outranks larger
  assign admit_level = irq_level < mask_now;
  assign admit_mask = psw_reg.maskable_irq_enable & irq_ie & admit_level;
  assign accept_w = irq_req & (irq_nmi | admit_mask);
  // Flag results from the ALU
  logic res_zero, res_neg;
  assign res_zero = alu_word ? (alu_result == 16'h0000) : (alu_result[7:0] == 8'h00);
  assign res_neg = alu_word ? alu_result[15] : alu_result[7];
  // Next status value; return beats all, then software, then acceptance
  always_comb begin
    psw_next = psw_reg;
    if (reti) begin
      psw_next = csag_psw_t'(stack_rdata);
    end else if (psw_wr) begin
      psw_next = csag_psw_t'(psw_wdata);
    end else begin
      if (alu_valid) begin
        psw_next.zero_flag = res_zero;
        psw_next.negative_flag = res_neg;
        psw_next.carry_flag = alu_carry;
        psw_next.overflow_flag = alu_is_arith & alu_ovf;
      end
      if (accept_w && !irq_nmi) begin
        // Only the mask changes; enable kept
        psw_next.mask_level_hi = irq_level[1];
        psw_next.mask_level_lo = irq_level[0];
      end
    end
    psw_next.zero = 1'b0;
  end
  // Status update
  always_ff @(posedge clk) begin
    if (srst) begin
      psw_reg <= csag_psw_t'(CSAG_PSW_RESET);
      psw_q <= CSAG_PSW_RESET;
      irq_accept <= 1'b0;
      push_valid <= 1'b0;
      push_data <= 8'h00;
    end else begin
      psw_reg <= psw_next;
      psw_q <= psw_next;
      irq_accept <= accept_w;
      push_valid <= accept_w;
      push_data <= psw_reg;
    end
  end
  // ----------------------------------------------------------------
  // Effective address generation
  // ----------------------------------------------------------------
  logic [17:0] ea_w, last_addr_reg;
  logic [15:0] off16;
  logic [17:0] bank_base;
  logic [PC_W-1:0] pc_disp, pc_sum;
  logic ea_bad;
  assign bank_base = {data_bank, 16'h0000};
  // Nibble-unit branch displacement, sign extended
  assign pc_disp = PC_W'(signed'(areq.disp));
  assign pc_sum = pc + pc_disp;
  // Data address offset selection
  always_comb begin
    off16 = 16'h0000;
    unique case (areq.mode)
      CSAG_AM_REG_IND: off16 = areq.areg;
      CSAG_AM_REG_D8: off16 = areq.areg + {{8{areq.disp[7]}}, areq.disp[7:0]};
      CSAG_AM_REG_D16: off16 = areq.areg + areq.disp;
      CSAG_AM_SP_D4: off16 = sp + {12'h000, areq.disp[3:0]};
      CSAG_AM_SP_D8: off16 = sp + {8'h00, areq.disp[7:0]};
      CSAG_AM_SP_D16: off16 = sp + areq.disp;
      CSAG_AM_ABS8: off16 = {8'h00, areq.abs_op[7:0]};
      CSAG_AM_ABS12: off16 = {4'h0, areq.abs_op[11:0]};
      CSAG_AM_ABS16: off16 = areq.abs_op[15:0];
      CSAG_AM_RAM_SHORT: off16 = CSAG_RAM_SHORT_BASE[15:0] + {8'h00, areq.abs_op[7:0]};
      CSAG_AM_IO_SHORT: off16 = CSAG_SFR_BASE[15:0] + {8'h00, areq.abs_op[7:0]};
      default: off16 = 16'h0000;
    endcase
  end
  // Full address with bank; I/O and RAM short are absolute in bank zero
  always_comb begin
    ea_w = bank_base | {2'b00, off16};
    ea_bad = 1'b0;
    if (areq.mode == CSAG_AM_IO_SHORT || areq.mode == CSAG_AM_RAM_SHORT) begin
      ea_w = {2'b00, off16};
    end else if (areq.mode == CSAG_AM_HANDY) begin
      ea_w = last_addr_reg;
      ea_bad = !areq.is_move;
    end else if (areq.mode == CSAG_AM_ABS18) begin
      ea_w = areq.abs_op;
      ea_bad = !areq.is_branch;
    end else if (areq.mode == CSAG_AM_PC_REL) begin
      ea_w = pc_sum[18:1];
      ea_bad = !areq.is_branch;
    end
  end
  // Word transfer sequencing as two byte cycles
  csag_state_t st_reg, st_next;
  logic start_w, data_w;
  assign data_w = areq.mode != CSAG_AM_PC_REL && areq.mode != CSAG_AM_ABS18;
  assign start_w = areq.valid & !ea_bad & (st_reg == CSAG_ST_IDLE);
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      CSAG_ST_IDLE: if (start_w && areq.is_word && data_w) st_next = CSAG_ST_HIGH;
      CSAG_ST_HIGH: st_next = CSAG_ST_IDLE;
    endcase
  end
  // Address outputs and memory of last access
  always_ff @(posedge clk) begin
    if (srst) begin
      st_reg <= CSAG_ST_IDLE;
      addr_valid <= 1'b0;
      addr_q <= 18'h00000;
      addr_sfr <= 1'b0;
      addr_err <= 1'b0;
      branch_target <= 18'h00000;
      pc_q <= '0;
      last_addr_reg <= CSAG_LAST_ADDR_RESET;
    end else begin
      st_reg <= st_next;
      pc_q <= pc;
      addr_err <= areq.valid & ea_bad & (st_reg == CSAG_ST_IDLE);
      if (st_reg == CSAG_ST_HIGH) begin
        addr_valid <= 1'b1;
        addr_q <= addr_q + 18'h00001;
        addr_sfr <= (addr_q + 18'h00001) >= CSAG_SFR_BASE && (addr_q + 18'h00001) <= CSAG_SFR_LAST;
      end else if (start_w && data_w) begin
        addr_valid <= 1'b1;
        addr_q <= ea_w;
        addr_sfr <= (ea_w >= CSAG_SFR_BASE) && (ea_w <= CSAG_SFR_LAST);
        last_addr_reg <= ea_w;
      end else begin
        addr_valid <= 1'b0;
      end
      if (start_w && !data_w) begin
        branch_target <= ea_w;
      end
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Reserved bit never set
  property p_bit7;
    @(posedge clk) disable iff (srst) psw_q[7] == 1'b0;
  endproperty
  a_bit7: assert property (p_bit7) else $error("reserved bit set");
  // Acceptance pushes the old status word
  property p_push;
    @(posedge clk) disable iff (srst) accept_w |=> push_valid && push_data == $past(psw_reg);
  endproperty
  a_push: assert property (p_push) else $error("push missing");
  // Zero byte result sets the zero flag
  property p_zero;
    @(posedge clk) disable iff (srst)
      (alu_valid && !reti && !psw_wr && !alu_word && alu_result[7:0] == 8'h00) |=> psw_q[0];
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  // Nonzero word result clears the zero flag
  property p_wzero;
    @(posedge clk) disable iff (srst)
      (alu_valid && !reti && !psw_wr && alu_word && alu_result != 16'h0000) |=> !psw_q[0];
  endproperty
  a_wzero: assert property (p_wzero) else $error("word zero flag wrong");
  // Carry follows the ALU carry out
  property p_carry;
    @(posedge clk) disable iff (srst) (alu_valid && !reti && !psw_wr) |=> psw_q[1] == $past(alu_carry);
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");
  // Negative follows the top bit of a byte result
  property p_neg;
    @(posedge clk) disable iff (srst)
      (alu_valid && !reti && !psw_wr && !alu_word) |=> psw_q[2] == $past(alu_result[7]);
  endproperty
  a_neg: assert property (p_neg) else $error("negative flag wrong");
  // Logic operations never report overflow
  property p_ovf;
    @(posedge clk) disable iff (srst) (alu_valid && !reti && !psw_wr && !alu_is_arith) |=> !psw_q[3];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
  // Disabled maskable requests are never taken
  property p_mie;
    @(posedge clk) disable iff (srst) (!psw_reg.maskable_irq_enable && !irq_nmi) |-> !accept_w;
  endproperty
  a_mie: assert property (p_mie) else $error("masked request taken");
  // Levels not below the mask are refused
  property p_level;
    @(posedge clk) disable iff (srst) (!irq_nmi && irq_level >= mask_now) |-> !accept_w;
  endproperty
  a_level: assert property (p_level) else $error("low priority taken");
  // Non-maskable request always taken
  property p_nmi;
    @(posedge clk) disable iff (srst) (irq_req && irq_nmi) |=> irq_accept;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi refused");
  // Acceptance loads the mask and keeps the enable
  property p_mask;
    @(posedge clk) disable iff (srst) (accept_w && !irq_nmi && !reti && !psw_wr) |=>
      psw_q[5:4] == $past(irq_level) && psw_q[6] == $past(psw_reg.maskable_irq_enable);
  endproperty
  a_mask: assert property (p_mask) else $error("mask load wrong");
  // Enable bit survives any acceptance
  property p_keep_mie;
    @(posedge clk) disable iff (srst)
      (accept_w && !reti && !psw_wr) |=> psw_q[6] == $past(psw_reg.maskable_irq_enable);
  endproperty
  a_keep_mie: assert property (p_keep_mie) else $error("enable changed");
  // I/O short lands in the special register page
  property p_io;
    @(posedge clk) disable iff (srst) (start_w && areq.mode == CSAG_AM_IO_SHORT) |=>
      addr_q == {10'h03F, $past(areq.abs_op[7:0])} && addr_sfr;
  endproperty
  a_io: assert property (p_io) else $error("io short address wrong");
  // RAM short lands in the first page
  property p_ram;
    @(posedge clk) disable iff (srst) (start_w && areq.mode == CSAG_AM_RAM_SHORT) |=>
      addr_q == {10'h000, $past(areq.abs_op[7:0])};
  endproperty
  a_ram: assert property (p_ram) else $error("ram short address wrong");
  // Absolute 16-bit data accesses carry the selected bank
  property p_bank;
    @(posedge clk) disable iff (srst) (start_w && areq.mode == CSAG_AM_ABS16) |=>
      addr_q[17:16] == $past(data_bank);
  endproperty
  a_bank: assert property (p_bank) else $error("bank wrong");
  // Register indirect uses the register alone
  property p_regind;
    @(posedge clk) disable iff (srst) (start_w && areq.mode == CSAG_AM_REG_IND) |=>
      addr_q[15:0] == $past(areq.areg);
  endproperty
  a_regind: assert property (p_regind) else $error("register address wrong");
  // Short stack displacement added unsigned
  property p_spd4;
    @(posedge clk) disable iff (srst) (start_w && areq.mode == CSAG_AM_SP_D4) |=>
      addr_q[15:0] == $past(sp) + $past({12'h000, areq.disp[3:0]});
  endproperty
  a_spd4: assert property (p_spd4) else $error("stack address wrong");
  // Long absolute refused outside branches
  property p_abs18;
    @(posedge clk) disable iff (srst) (areq.valid && st_reg == CSAG_ST_IDLE &&
      areq.mode == CSAG_AM_ABS18 && !areq.is_branch) |=> addr_err && !addr_valid;
  endproperty
  a_abs18: assert property (p_abs18) else $error("abs18 not refused");
  // Branch target takes the long absolute operand
  property p_btgt;
    @(posedge clk) disable iff (srst) (start_w && areq.mode == CSAG_AM_ABS18) |=>
      branch_target == $past(areq.abs_op);
  endproperty
  a_btgt: assert property (p_btgt) else $error("branch target wrong");
  // Handy mode refused outside moves
  property p_handy;
    @(posedge clk) disable iff (srst) (areq.valid && st_reg == CSAG_ST_IDLE &&
      areq.mode == CSAG_AM_HANDY && !areq.is_move) |=> addr_err && !addr_valid;
  endproperty
  a_handy: assert property (p_handy) else $error("handy not refused");
  // Special register flag marks the register page
  property p_sfr;
    @(posedge clk) disable iff (srst)
      addr_valid |-> addr_sfr == (addr_q >= 18'h03F00 && addr_q <= 18'h03FFF);
  endproperty
  a_sfr: assert property (p_sfr) else $error("sfr decode wrong");
  // Program counter copy lags one cycle
  property p_pc;
    @(posedge clk) disable iff (srst) 1'b1 |=> pc_q == $past(pc);
  endproperty
  a_pc: assert property (p_pc) else $error("pc copy wrong");
  // Word access gives two consecutive bytes
  property p_word;
    @(posedge clk) disable iff (srst) (start_w && data_w && areq.is_word) |=>
      addr_valid ##1 (addr_valid && addr_q == $past(addr_q) + 18'h00001);
  endproperty
  a_word: assert property (p_word) else $error("word split wrong");
  c_word: cover property (@(posedge clk) disable iff (srst) start_w && data_w && areq.is_word);
  c_accept: cover property (@(posedge clk) disable iff (srst) accept_w && !irq_nmi);
  c_reti: cover property (@(posedge clk) disable iff (srst) reti);
  c_handy: cover property (@(posedge clk) disable iff (srst) start_w && areq.mode == CSAG_AM_HANDY);
  c_branch: cover property (@(posedge clk) disable iff (srst) start_w && !data_w);
endmodule : csag_core
`default_nettype wire

/* rtl/csag_pkg.sv */
// Constants and types for the CPU status and address generator
package csag_pkg;
  // ----------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CSAG_PSW_RESET = 8'h00;
  localparam int CSAG_BIT_MIE = 6;
  localparam int CSAG_BIT_VF = 3;
  localparam int CSAG_BIT_NF = 2;
  localparam int CSAG_BIT_CF = 1;
  localparam int CSAG_BIT_ZF = 0;
  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [17:0] CSAG_SFR_BASE = 18'h03F00;
  localparam logic [17:0] CSAG_SFR_LAST = 18'h03FFF;
  localparam logic [17:0] CSAG_RAM_SHORT_BASE = 18'h00000;
  localparam logic [1:0] CSAG_BANK_RESET = 2'h0;
  localparam logic [17:0] CSAG_LAST_ADDR_RESET = 18'h00000;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic zero;      // reserved bit 7
    logic maskable_irq_enable;
    logic mask_level_hi;
    logic mask_level_lo;
    logic overflow_flag;
    logic negative_flag;
    logic carry_flag;
    logic zero_flag;
  } csag_psw_t;
  // Addressing modes
  typedef enum logic [3:0] {
    CSAG_AM_REG_IND, CSAG_AM_REG_D8, CSAG_AM_REG_D16,
    CSAG_AM_PC_REL, CSAG_AM_SP_D4, CSAG_AM_SP_D8, CSAG_AM_SP_D16,
    CSAG_AM_ABS8, CSAG_AM_ABS12, CSAG_AM_ABS16, CSAG_AM_ABS18,
    CSAG_AM_RAM_SHORT, CSAG_AM_IO_SHORT, CSAG_AM_HANDY
  } csag_mode_t;
  // Address request from the decoder
  typedef struct packed {
    logic valid;
    csag_mode_t mode;
    logic is_branch;
    logic is_move;
    logic is_word;
    logic [15:0] areg;
    logic [15:0] disp;
    logic [17:0] abs_op;
  } csag_areq_t;
  // Word transfer phases
  typedef enum logic [1:0] {CSAG_ST_IDLE, CSAG_ST_HIGH} csag_state_t;
endpackage : csag_pkg

/* verif/csag_stack_model.sv */
// Stack memory model that keeps pushed status words for restore
`timescale 1ns/10ps
`default_nettype none
module csag_stack_model (
  input wire logic clk,
  input wire logic push_valid,
  input wire logic [7:0] push_data,
  input wire logic pop,
  output logic [7:0] stack_rdata
);
  logic [7:0] mem_reg [0:7]; // Stack storage
  logic [2:0] ptr_reg = 3'h0; // Count of stored words
  logic [7:0] last_reg = 8'h00; // Last value shown
  // Top of stack; an empty stack shows a value that keeps changing
  assign stack_rdata = (ptr_reg != 3'h0) ? mem_reg[ptr_reg - 3'h1] : ~last_reg;
  // Push on entry, pop on return
  always_ff @(posedge clk) begin
    if (push_valid) begin
      mem_reg[ptr_reg] <= push_data;
      ptr_reg <= ptr_reg + 3'h1;
    end else if (pop && ptr_reg != 3'h0) begin
      ptr_reg <= ptr_reg - 3'h1;
    end
    last_reg <= stack_rdata;
  end
endmodule : csag_stack_model
`default_nettype wire

/* verif/cpu_status_and_address_gen_bench.sv */
// Self-checking bench for the status word and address generator
`timescale 1ns/10ps
`default_nettype none
module cpu_status_and_address_gen_bench import csag_pkg::*; ;
  csag_areq_t areq = '0;
  logic clk = 1'b0, srst = 1'b1, alu_valid = 1'b0, alu_is_arith = 1'b0, alu_word = 1'b0;
  logic alu_carry = 1'b0, alu_ovf = 1'b0, psw_wr = 1'b0, irq_req = 1'b0, irq_nmi = 1'b0;
  logic irq_ie = 1'b0, reti = 1'b0, br_win = 1'b0, irq_accept, push_valid, addr_valid;
  logic addr_sfr, addr_err;
  logic [1:0] data_bank = 2'h0, irq_level = 2'h0;
  logic [15:0] sp = 16'h0, alu_result = 16'h0;
  logic [18:0] pc = 19'h0, pc_q;
  logic [7:0] psw_wdata = 8'h0, stack_rdata, psw_q, push_data, m_psw = 8'h0;
  logic [17:0] addr_q, branch_target, last_a = 18'h0, e;
  logic [20:0] q [$]; // Expected results, oldest first
  int fail_count = 0, check_count = 0, cyc = 0;
  csag_core u_csag_core (.clk(clk), .srst(srst), .areq(areq), .sp(sp), .pc(pc),
    .data_bank(data_bank), .alu_valid(alu_valid), .alu_is_arith(alu_is_arith),
    .alu_word(alu_word), .alu_result(alu_result), .alu_carry(alu_carry), .alu_ovf(alu_ovf),
    .psw_wr(psw_wr), .psw_wdata(psw_wdata), .irq_req(irq_req), .irq_nmi(irq_nmi),
    .irq_level(irq_level), .irq_ie(irq_ie), .reti(reti), .stack_rdata(stack_rdata),
    .psw_q(psw_q), .irq_accept(irq_accept), .push_valid(push_valid), .push_data(push_data),
    .addr_valid(addr_valid), .addr_q(addr_q), .addr_sfr(addr_sfr), .addr_err(addr_err),
    .branch_target(branch_target), .pc_q(pc_q));
  csag_stack_model u_csag_stack_model (.clk(clk), .push_valid(push_valid),
    .push_data(push_data), .pop(reti), .stack_rdata(stack_rdata));
  // Clock and hang guard
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic check(input logic [20:0] seen, input logic [20:0] expv);
    check_count++;
    if (seen !== expv) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask : check
  task automatic complete_run();
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  // Compare an observed result with the oldest note
  task automatic take(input logic [20:0] v);
    if (q.size() == 0) check(v, 21'h1FFFFF);
    else check(v, q.pop_front());
  endtask : take
  // Output watcher, sampling after the edge has settled
  always @(posedge clk) begin
    #1;
    if (addr_valid === 1'b1 && !br_win) take({2'h1, addr_sfr, addr_q});
    if (addr_err === 1'b1) take({2'h2, 19'h0});
    if (irq_accept === 1'b1) take({2'h3, push_valid, 10'h0, push_data});
  end
  function automatic logic sfr(input logic [17:0] a);
    return a >= CSAG_SFR_BASE && a <= CSAG_SFR_LAST;
  endfunction : sfr
  // Expected address for each mode
  function automatic logic [17:0] ea(input csag_mode_t m);
    logic [18:0] s;
    s = pc + {{3{areq.disp[15]}}, areq.disp};
    case (m)
      CSAG_AM_REG_IND: return {data_bank, areq.areg};
      CSAG_AM_REG_D8: return {data_bank, areq.areg + {{8{areq.disp[7]}}, areq.disp[7:0]}};
      CSAG_AM_REG_D16: return {data_bank, areq.areg + areq.disp};
      CSAG_AM_SP_D4: return {data_bank, sp + {12'h0, areq.disp[3:0]}};
      CSAG_AM_SP_D8: return {data_bank, sp + {8'h0, areq.disp[7:0]}};
      CSAG_AM_SP_D16: return {data_bank, sp + areq.disp};
      CSAG_AM_ABS8: return {data_bank, 8'h0, areq.abs_op[7:0]};
      CSAG_AM_ABS12: return {data_bank, 4'h0, areq.abs_op[11:0]};
      CSAG_AM_ABS16: return {data_bank, areq.abs_op[15:0]};
      CSAG_AM_RAM_SHORT: return {10'h0, areq.abs_op[7:0]};
      CSAG_AM_IO_SHORT: return CSAG_SFR_BASE + {10'h0, areq.abs_op[7:0]};
      CSAG_AM_HANDY: return last_a;
      CSAG_AM_ABS18: return areq.abs_op;
      default: return s[18:1];
    endcase
  endfunction : ea
  // Flag update from one result
  task automatic alu(input logic w, input logic ar);
    @(negedge clk);
    {alu_result, alu_carry, alu_ovf} = 18'($urandom);
    if ($urandom % 4 == 0) alu_result = 16'h0;
    alu_word = w;
    alu_is_arith = ar;
    alu_valid = 1'b1;
    m_psw[3] = ar & alu_ovf;
    m_psw[2] = w ? alu_result[15] : alu_result[7];
    m_psw[1] = alu_carry;
    m_psw[0] = w ? (alu_result == 16'h0) : (alu_result[7:0] == 8'h0);
    @(negedge clk);
    alu_valid = 1'b0;
    check(21'(psw_q), 21'(m_psw));
  endtask : alu
  // Software write of the status word
  task automatic wr(input logic [7:0] d);
    @(negedge clk);
    psw_wdata = d;
    psw_wr = 1'b1;
    @(negedge clk);
    psw_wr = 1'b0;
    m_psw = {1'b0, d[6:0]};
    check(21'(psw_q), 21'(m_psw));
  endtask : wr
  // One request under judgement, then a return when accepted
  task automatic irq(input logic n, input logic [1:0] lv, input logic ie);
    logic acc;
    logic [7:0] old;
    acc = n | (m_psw[6] & ie & (lv < m_psw[5:4]));
    old = m_psw;
    if (acc) q.push_back({2'h3, 1'b1, 10'h0, old});
    @(negedge clk);
    irq_nmi = n;
    irq_level = lv;
    irq_ie = ie;
    irq_req = 1'b1;
    @(negedge clk);
    irq_req = 1'b0;
    if (acc && !n) m_psw[5:4] = lv;
    @(negedge clk);
    check(21'(psw_q), 21'(m_psw));
    if (acc) begin
      reti = 1'b1;
      @(negedge clk);
      reti = 1'b0;
      m_psw = old;
      check(21'(psw_q), 21'(old));
    end
  endtask : irq
  // One address request with its expected byte accesses or refusal
  task automatic ad(input csag_mode_t m, input logic br, input logic mv, input logic wd);
    @(negedge clk);
    areq = csag_areq_t'({$urandom, $urandom});
    areq.valid = 1'b1;
    areq.mode = m;
    areq.is_branch = br;
    areq.is_move = mv;
    areq.is_word = wd;
    data_bank = 2'($urandom);
    sp = 16'($urandom);
    pc = 19'($urandom);
    e = ea(m);
    br_win = br;
    if ((m == CSAG_AM_HANDY && !mv) || ((m == CSAG_AM_ABS18 || m == CSAG_AM_PC_REL) && !br))
      q.push_back({2'h2, 19'h0});
    else if (!br) begin
      q.push_back({2'h1, sfr(e), e});
      last_a = e;
      if (wd) q.push_back({2'h1, sfr(e + 18'h1), e + 18'h1});
    end
    @(negedge clk);
    areq.valid = 1'b0;
    check(21'(pc_q), 21'(pc));
    repeat (2) @(negedge clk);
    if (br) check(21'(branch_target), 21'(e));
    br_win = 1'b0;
  endtask : ad
  // Main sequence
  initial begin
    void'($urandom(32'hdc4e));
    repeat (2) @(negedge clk);
    srst = 1'b0;
    check(21'(psw_q), 21'(CSAG_PSW_RESET));
    repeat (12) alu(1'($urandom), 1'($urandom));
    wr(8'hFF);
    for (int m = 0; m < 16; m++) begin
      for (int l = 0; l < 4; l++) begin
        wr({1'b0, 1'(m), 2'(m >> 2), 4'($urandom)});
        irq(1'b0, 2'(l), 1'b1);
      end
    end
    irq(1'b0, 2'h0, 1'b0);
    wr(8'h00);
    irq(1'b1, 2'h3, 1'b0);
    for (int i = 0; i < 14; i++) ad(csag_mode_t'(i), i == 3, 1'b1, i == 9 || i == 12);
    ad(CSAG_AM_PC_REL, 1'b0, 1'b1, 1'b0);
    ad(CSAG_AM_HANDY, 1'b0, 1'b0, 1'b0);
    ad(CSAG_AM_ABS18, 1'b1, 1'b1, 1'b0);
    repeat (40) begin
      e = 18'($urandom % 14);
      ad(csag_mode_t'(e[3:0]), 1'b0, 1'($urandom), 1'($urandom) && e != 18'hD);
    end
    repeat (3) @(negedge clk);
    check(21'(q.size()), 21'h0);
    complete_run();
  end
endmodule : cpu_status_and_address_gen_bench
`default_nettype wire
